// ===== dic_regs.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * input conditioner. Assumes an 8-bit word-aligned register address.
 */
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH

`define DIC_CLK_KHZ        10000
`define DIC_STEP_MS        1
`define DIC_SCAN_MS        5
`define DIC_AC_HOLD_MS     30

`define DIC_ADDR_W         8
`define DIC_DATA_W         32
`define DIC_DELAY_W        21
`define DIC_NUM_IN         3
`define DIC_NUM_OUT        5
`define DIC_CNT_W          32

`define DIC_OFF_CTRL       8'h00
`define DIC_OFF_ACT_BASE   8'h04
`define DIC_OFF_DROP_BASE  8'h10
`define DIC_OFF_OUT_CTL    8'h20
`define DIC_OFF_ROUTE      8'h24
`define DIC_OFF_FAULT      8'h28
`define DIC_OFF_STATUS     8'h2C
`define DIC_OFF_CNT_BASE   8'h30

`define DIC_SLOT_MISS      2'h3
`define DIC_CTRL_POL_LSB   0
`define DIC_CTRL_AC_LSB    4
`define DIC_ST_CHAN_LSB    0
`define DIC_ST_STAGE_LSB   4
`define DIC_ST_OUT_LSB     8
`define DIC_ST_RELAY_BIT   16
`define DIC_ST_FPIN_BIT    17

`define DIC_ROUTE_W        2
`define DIC_ROUTE_SW       2'h0
`define DIC_ROUTE_IN1      2'h1

`define DIC_POL_RESET      3'h0
`define DIC_AC_RESET       3'h0
`define DIC_DELAY_RESET    21'h00000
`define DIC_OUT_RESET      5'h00
`define DIC_ROUTE_RESET    10'h000

`endif

// ===== dic_pkg.sv
/*
 * Types shared by the input conditioner modules.
 * Assumes dic_regs.svh is on the include path.
 */
`include "dic_regs.svh"

package dic_pkg;

	typedef enum logic {
		ch_inactive,
		ch_active
	} dic_chan_state_t;

	typedef struct packed {
		logic                    polarity_nc;
		logic                    ac_holdoff;
		logic [`DIC_DELAY_W-1:0] act_delay;
		logic [`DIC_DELAY_W-1:0] drop_delay;
	} dic_chan_cfg_t;

endpackage : dic_pkg

// ===== dic_scan_timer.sv
/*
 * Millisecond step and 5 ms scan strobes.
 * Assumes one free-running system clock; MS_CYCLES clocks per step.
 */
`timescale 1ns/1ps
`include "dic_regs.svh"

module dic_scan_timer import dic_pkg::*; #(
	parameter int MS_CYCLES = `DIC_CLK_KHZ * `DIC_STEP_MS
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Strobes, one cycle each
	output logic      ms_tick,
	output logic      scan_tick
);

	localparam int             MS_W      = (MS_CYCLES > 2) ? $clog2(MS_CYCLES) : 1;
	localparam logic [MS_W-1:0] MS_LAST  = MS_W'(MS_CYCLES - 1);
	localparam logic [2:0]     SCAN_LAST = 3'(`DIC_SCAN_MS / `DIC_STEP_MS - 1);

	logic [MS_W-1:0] ms_cnt_reg, ms_cnt_next;
	logic [2:0]      scan_cnt_reg, scan_cnt_next;
	logic            ms_tick_reg, ms_tick_next;
	logic            scan_tick_reg, scan_tick_next;

	always_comb begin
		ms_tick_next   = (ms_cnt_reg == MS_LAST);
		ms_cnt_next    = ms_tick_next ? '0 : ms_cnt_reg + 1'b1;
		scan_cnt_next  = scan_cnt_reg;
		scan_tick_next = 1'b0;
		if (ms_tick_next) begin
			scan_tick_next = (scan_cnt_reg == SCAN_LAST);
			scan_cnt_next  = scan_tick_next ? 3'h0 : scan_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ms_cnt_reg    <= '0;
			scan_cnt_reg  <= 3'h0;
			ms_tick_reg   <= 1'b0;
			scan_tick_reg <= 1'b0;
		end else begin
			ms_cnt_reg    <= ms_cnt_next;
			scan_cnt_reg  <= scan_cnt_next;
			ms_tick_reg   <= ms_tick_next;
			scan_tick_reg <= scan_tick_next;
		end
	end

	assign ms_tick   = ms_tick_reg;
	assign scan_tick = scan_tick_reg;

	scan_on_ms_a: assert property (@(posedge clk) disable iff (!reset_n)
		scan_tick |-> ms_tick && scan_cnt_reg == 3'h0)
		else $error("scan strobe not aligned to a step");
	ms_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
		ms_tick |-> ms_cnt_reg == '0)
		else $error("step strobe without counter wrap");

endmodule : dic_scan_timer

// ===== dic_input_channel.sv
/*
 * One conditioned input: polarity, scan sampling, pick-up and release
 * delays with optional AC hold-off. Assumes pin_level is synchronised.
 */
`timescale 1ns/1ps
`include "dic_regs.svh"

module dic_input_channel import dic_pkg::*; (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// Timing strobes
	input  wire logic          ms_tick,
	input  wire logic          scan_tick,
	// Field level and settings
	input  wire logic          pin_level,
	input  wire dic_chan_cfg_t cfg,
	// Conditioned state
	output logic               status,
	output logic               activated
);

	localparam logic [`DIC_DELAY_W:0] AC_HOLD = (`DIC_DELAY_W+1)'(`DIC_AC_HOLD_MS / `DIC_STEP_MS);

	dic_chan_state_t         state_reg, state_next;
	logic                    sample_reg, sample_next;
	logic [`DIC_DELAY_W:0]   cnt_reg, cnt_next;
	logic [`DIC_DELAY_W:0]   target;
	logic                    active;

	assign active = (state_reg == ch_active);

	always_comb begin
		sample_next = sample_reg;
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		if (active) begin
			target = {1'b0, cfg.drop_delay} + (cfg.ac_holdoff ? AC_HOLD : '0);
		end else begin
			target = {1'b0, cfg.act_delay};
		end
		if (scan_tick) begin
			sample_next = pin_level ^ cfg.polarity_nc;
		end
		if (sample_reg == active) begin
			cnt_next = '0;
		end else if (cnt_reg >= target) begin
			state_next = active ? ch_inactive : ch_active;
			cnt_next   = '0;
		end else if (ms_tick) begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg  <= ch_inactive;
			sample_reg <= 1'b0;
			cnt_reg    <= '0;
		end else begin
			state_reg  <= state_next;
			sample_reg <= sample_next;
			cnt_reg    <= cnt_next;
		end
	end

	assign status    = active;
	assign activated = !active && (state_next == ch_active);

	sequence rise_ready_s;
		!active && sample_reg && cnt_reg >= {1'b0, cfg.act_delay};
	endsequence

	sequence hold_pending_s;
		active && !sample_reg && cfg.ac_holdoff && cnt_reg < AC_HOLD;
	endsequence

	rise_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
		rise_ready_s |=> active)
		else $error("pick-up missed after delay");
	ac_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		hold_pending_s |=> active)
		else $error("released inside AC hold-off");
	restart_a: assert property (@(posedge clk) disable iff (!reset_n)
		(sample_reg == active) |=> cnt_reg == '0)
		else $error("delay counter not restarted");
	polarity_sample_a: assert property (@(posedge clk) disable iff (!reset_n)
		scan_tick |=> sample_reg == ($past(pin_level) ^ $past(cfg.polarity_nc)))
		else $error("sample ignores polarity");

endmodule : dic_input_channel

// ===== dic_conditioner_top.sv
/*
 * Base digital inputs, relay output drive and system-fault relay of a
 * protection relay processor module, with a plain register port.
 * Assumes field pins are asynchronous and reach here as logic levels.
 */
`timescale 1ns/1ps
`include "dic_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Per-input polarity, default energized reads one
// - Rising status waits programmed activation delay
// - Falling status waits separate drop-off delay
// - AC option adds 30 ms release hold-off
// - Inputs sampled once per 5 ms scan
// - Internal use lags at most one scan
// - Routed output lags one further scan
// - Outputs refreshed every 5 ms scan
// - Fault relay energized only when healthy
// - Four open outputs plus changeover signal relay
////////////////////////////////////////////////////////////////////////////////

module dic_conditioner_top import dic_pkg::*; #(
	parameter int MS_CYCLES = `DIC_CLK_KHZ * `DIC_STEP_MS
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// Register port
	input  wire logic [`DIC_ADDR_W-1:0] reg_addr,
	input  wire logic [`DIC_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [`DIC_DATA_W-1:0] reg_rdata,
	// Field inputs
	input  wire logic [`DIC_NUM_IN-1:0] input_channel_n,
	input  wire logic                   fault_pin,
	// Relay drives
	output logic [`DIC_NUM_OUT-1:0]     output_channel_n,
	output logic                        sys_fault_relay
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic logic [1:0] slot_of(input logic [`DIC_ADDR_W-1:0] addr,
		input logic [`DIC_ADDR_W-1:0] base);
		logic [`DIC_ADDR_W-1:0] diff;
		diff = addr - base;
		if (diff[1:0] == 2'h0 && diff[`DIC_ADDR_W-1:2] < (`DIC_ADDR_W-2)'(`DIC_NUM_IN)) begin
			slot_of = diff[3:2];
		end else begin
			slot_of = `DIC_SLOT_MISS;
		end
	endfunction : slot_of

	function automatic logic route_pick(input logic [`DIC_ROUTE_W-1:0] sel, input logic sw_bit,
		input logic [`DIC_NUM_IN-1:0] states);
		if (sel == `DIC_ROUTE_SW) begin
			route_pick = sw_bit;
		end else begin
			route_pick = states[sel - `DIC_ROUTE_IN1];
		end
	endfunction : route_pick

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [`DIC_NUM_IN:0] sync1_reg, sync2_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {fault_pin, input_channel_n};
			sync2_reg <= sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timing and channels

	logic                   ms_tick;
	logic                   scan_tick;
	logic [`DIC_NUM_IN-1:0] chan_status;
	logic [`DIC_NUM_IN-1:0] chan_rise;
	dic_chan_cfg_t          chan_cfg [`DIC_NUM_IN];

	dic_scan_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.clk       (clk),
		.reset_n   (reset_n),
		.ms_tick   (ms_tick),
		.scan_tick (scan_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic [`DIC_NUM_IN-1:0]  pol_reg, pol_next;
	logic [`DIC_NUM_IN-1:0]  ac_reg, ac_next;
	logic [`DIC_DELAY_W-1:0] act_reg [`DIC_NUM_IN];
	logic [`DIC_DELAY_W-1:0] act_next [`DIC_NUM_IN];
	logic [`DIC_DELAY_W-1:0] drop_reg [`DIC_NUM_IN];
	logic [`DIC_DELAY_W-1:0] drop_next [`DIC_NUM_IN];
	logic [`DIC_NUM_OUT-1:0] out_ctl_reg, out_ctl_next;
	logic [2*`DIC_NUM_OUT-1:0] route_reg, route_next;
	logic                    sw_fault_reg, sw_fault_next;
	logic [1:0]              act_slot, drop_slot, cnt_slot;

	assign act_slot  = slot_of(reg_addr, `DIC_OFF_ACT_BASE);
	assign drop_slot = slot_of(reg_addr, `DIC_OFF_DROP_BASE);
	assign cnt_slot  = slot_of(reg_addr, `DIC_OFF_CNT_BASE);

	always_comb begin
		pol_next      = pol_reg;
		ac_next       = ac_reg;
		act_next      = act_reg;
		drop_next     = drop_reg;
		out_ctl_next  = out_ctl_reg;
		route_next    = route_reg;
		sw_fault_next = sw_fault_reg;
		if (reg_wr) begin
			if (reg_addr == `DIC_OFF_CTRL) begin
				pol_next = reg_wdata[`DIC_CTRL_POL_LSB +: `DIC_NUM_IN];
				ac_next  = reg_wdata[`DIC_CTRL_AC_LSB +: `DIC_NUM_IN];
			end else if (act_slot != `DIC_SLOT_MISS) begin
				act_next[act_slot] = reg_wdata[`DIC_DELAY_W-1:0];
			end else if (drop_slot != `DIC_SLOT_MISS) begin
				drop_next[drop_slot] = reg_wdata[`DIC_DELAY_W-1:0];
			end else if (reg_addr == `DIC_OFF_OUT_CTL) begin
				out_ctl_next = reg_wdata[`DIC_NUM_OUT-1:0];
			end else if (reg_addr == `DIC_OFF_ROUTE) begin
				route_next = reg_wdata[2*`DIC_NUM_OUT-1:0];
			end else if (reg_addr == `DIC_OFF_FAULT) begin
				sw_fault_next = reg_wdata[0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pol_reg      <= `DIC_POL_RESET;
			ac_reg       <= `DIC_AC_RESET;
			out_ctl_reg  <= `DIC_OUT_RESET;
			route_reg    <= `DIC_ROUTE_RESET;
			sw_fault_reg <= 1'b0;
			for (int i = 0; i < `DIC_NUM_IN; i++) begin
				act_reg[i]  <= `DIC_DELAY_RESET;
				drop_reg[i] <= `DIC_DELAY_RESET;
			end
		end else begin
			pol_reg      <= pol_next;
			ac_reg       <= ac_next;
			act_reg      <= act_next;
			drop_reg     <= drop_next;
			out_ctl_reg  <= out_ctl_next;
			route_reg    <= route_next;
			sw_fault_reg <= sw_fault_next;
		end
	end

	generate
		for (genvar g = 0; g < `DIC_NUM_IN; g++) begin : g_chan
			assign chan_cfg[g] = '{polarity_nc: pol_reg[g], ac_holdoff: ac_reg[g],
				act_delay: act_reg[g], drop_delay: drop_reg[g]};
			dic_input_channel u_chan (
				.clk       (clk),
				.reset_n   (reset_n),
				.ms_tick   (ms_tick),
				.scan_tick (scan_tick),
				.pin_level (sync2_reg[g]),
				.cfg       (chan_cfg[g]),
				.status    (chan_status[g]),
				.activated (chan_rise[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Activation counters; a write clears, a same-cycle pick-up still counts

	logic [`DIC_CNT_W-1:0] cnt_reg [`DIC_NUM_IN];
	logic [`DIC_CNT_W-1:0] cnt_next [`DIC_NUM_IN];

	always_comb begin
		for (int i = 0; i < `DIC_NUM_IN; i++) begin
			cnt_next[i] = cnt_reg[i];
			if (reg_wr && cnt_slot == 2'(i)) begin
				cnt_next[i] = '0;
			end
			if (chan_rise[i]) begin
				cnt_next[i] = cnt_next[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `DIC_NUM_IN; i++) begin
				cnt_reg[i] <= '0;
			end
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Internal stage, relay drives and fault relay

	logic [`DIC_NUM_IN-1:0]  stage_reg, stage_next;
	logic [`DIC_NUM_OUT-1:0] out_reg, out_next;
	logic                    relay_reg, relay_next;
	logic                    fault_now;

	assign fault_now = sync2_reg[`DIC_NUM_IN] | sw_fault_reg;

	always_comb begin
		stage_next = stage_reg;
		out_next   = out_reg;
		if (scan_tick) begin
			stage_next = chan_status;
		end
		if (scan_tick) begin
			for (int k = 0; k < `DIC_NUM_OUT; k++) begin
				out_next[k] = route_pick(route_reg[2*k +: 2], out_ctl_reg[k], stage_reg);
			end
		end
		relay_next = !fault_now;
	end

	// Reset holds the fault relay released, as on loss of power
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_reg <= '0;
			out_reg   <= `DIC_OUT_RESET;
			relay_reg <= 1'b0;
		end else begin
			stage_reg <= stage_next;
			out_reg   <= out_next;
			relay_reg <= relay_next;
		end
	end

	assign output_channel_n = out_reg;
	assign sys_fault_relay  = relay_reg;

	////////////////////////////////////////////////////////////////////////////
	// Read port

	logic [`DIC_DATA_W-1:0] rdata_reg, rdata_next;
	logic [`DIC_DATA_W-1:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[`DIC_ST_CHAN_LSB +: `DIC_NUM_IN]  = chan_status;
		status_word[`DIC_ST_STAGE_LSB +: `DIC_NUM_IN] = stage_reg;
		status_word[`DIC_ST_OUT_LSB +: `DIC_NUM_OUT]  = out_reg;
		status_word[`DIC_ST_RELAY_BIT]                = relay_reg;
		status_word[`DIC_ST_FPIN_BIT]                 = sync2_reg[`DIC_NUM_IN];
	end

	// Unmapped addresses read zero; data stand only in the cycle after the strobe
	always_comb begin
		rdata_next = '0;
		if (reg_rd) begin
			if (reg_addr == `DIC_OFF_CTRL) begin
				rdata_next[`DIC_CTRL_POL_LSB +: `DIC_NUM_IN] = pol_reg;
				rdata_next[`DIC_CTRL_AC_LSB +: `DIC_NUM_IN]  = ac_reg;
			end else if (act_slot != `DIC_SLOT_MISS) begin
				rdata_next[`DIC_DELAY_W-1:0] = act_reg[act_slot];
			end else if (drop_slot != `DIC_SLOT_MISS) begin
				rdata_next[`DIC_DELAY_W-1:0] = drop_reg[drop_slot];
			end else if (reg_addr == `DIC_OFF_OUT_CTL) begin
				rdata_next[`DIC_NUM_OUT-1:0] = out_ctl_reg;
			end else if (reg_addr == `DIC_OFF_ROUTE) begin
				rdata_next[2*`DIC_NUM_OUT-1:0] = route_reg;
			end else if (reg_addr == `DIC_OFF_FAULT) begin
				rdata_next[0] = sw_fault_reg;
			end else if (reg_addr == `DIC_OFF_STATUS) begin
				rdata_next = status_word;
			end else if (cnt_slot != `DIC_SLOT_MISS) begin
				rdata_next = cnt_reg[cnt_slot];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence route_in1_s;
		scan_tick && route_reg[1:0] == `DIC_ROUTE_IN1;
	endsequence

	property route_follow_p;
		logic v;
		@(posedge clk) disable iff (!reset_n)
		(route_in1_s, v = stage_reg[0]) |=> output_channel_n[0] == v;
	endproperty

	route_follow_a: assert property (route_follow_p)
		else $error("routed output missed stage value");
	out_on_scan_a: assert property (@(posedge clk) disable iff (!reset_n)
		!$stable(out_reg) |-> $past(scan_tick))
		else $error("output changed off scan");
	stage_on_scan_a: assert property (@(posedge clk) disable iff (!reset_n)
		!$stable(stage_reg) |-> $past(scan_tick))
		else $error("stage changed off scan");
	fault_release_a: assert property (@(posedge clk) disable iff (!reset_n)
		fault_now |=> !sys_fault_relay)
		else $error("fault relay held during fault");
	healthy_energize_a: assert property (@(posedge clk) disable iff (!reset_n)
		!fault_now |=> sys_fault_relay)
		else $error("fault relay not energized");

	sequence sw_pick_s;
		scan_tick && route_reg[2*(`DIC_NUM_OUT-1) +: 2] == `DIC_ROUTE_SW;
	endsequence

	stage_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
		scan_tick |=> stage_reg == $past(chan_status))
		else $error("stage missed input status");
	signal_relay_a: assert property (@(posedge clk) disable iff (!reset_n)
		sw_pick_s |=> output_channel_n[`DIC_NUM_OUT-1] == $past(out_ctl_reg[`DIC_NUM_OUT-1]))
		else $error("signal relay missed its drive");

endmodule : dic_conditioner_top

// ===== dic_field_model.sv
/*
 * Field side of the conditioner: contacts that energise the input pins
 * and relay coils fed by the drives. Assumes the conditioner's clock.
 */
`timescale 1ns/1ps
`include "dic_regs.svh"

module dic_field_model import dic_pkg::*; #(
	parameter int BOUNCE_CYCLES = 6
) (
	// Clock
	input  wire logic                    clk,
	// Contact commands
	input  wire logic [`DIC_NUM_IN-1:0]  contact_cmd,
	input  wire logic                    chatter_en,
	// Pins toward the conditioner
	output logic      [`DIC_NUM_IN-1:0]  pin_level,
	// Drives from the conditioner
	input  wire logic [`DIC_NUM_OUT-1:0] relay_drive,
	input  wire logic                    fault_drive,
	// Coil and fault contact state
	output logic      [`DIC_NUM_OUT-1:0] coil_on,
	output logic                         fault_contact
);
	logic [`DIC_NUM_IN-1:0] cmd_q       = '0;
	logic [`DIC_NUM_IN-1:0] chg_q       = '0;
	logic [`DIC_NUM_IN-1:0] pin_q       = '0;
	int                     bounce_left = 0;

	assign pin_level = pin_q;

	// Bounce stays far shorter than a scan, so one sample settles it
	always @(posedge clk) begin
		if (contact_cmd !== cmd_q) begin
			cmd_q       <= contact_cmd;
			chg_q       <= contact_cmd ^ cmd_q;
			bounce_left <= chatter_en ? BOUNCE_CYCLES : 0;
			pin_q       <= chatter_en ? pin_q ^ (contact_cmd ^ cmd_q) : contact_cmd;
		end else if (bounce_left > 0) begin
			bounce_left <= bounce_left - 1;
			pin_q       <= (bounce_left == 1) ? cmd_q : pin_q ^ chg_q;
		end
	end

	assign coil_on = relay_drive;
	assign fault_contact = ~fault_drive;
endmodule : dic_field_model

// ===== dic_conditioner_tb_top.sv
/*
 * Self-checking bench for the input conditioner top.
 * Assumes the design files and dic_field_model are compiled first.
 */
`timescale 1ns/1ps
`include "dic_regs.svh"

module dic_conditioner_tb_top import dic_pkg::*;;
	localparam int MS    = 10;
	localparam int SCAN  = `DIC_SCAN_MS * MS;
	localparam int LIMIT = 20000;
	localparam logic [7:0] REGS [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
		8'h20, 8'h24, 8'h28, 8'h30, 8'h3C, 8'h40};

	typedef struct packed {
		logic        chk;
		logic [31:0] exp;
		logic [31:0] mask;
	} dic_note_t;

	logic        clk         = 1'b0;
	logic        reset_n     = 1'b0;
	logic        reg_wr      = 1'b0;
	logic        reg_rd      = 1'b0;
	logic        rd_q        = 1'b0;
	logic        fault_pin   = 1'b0;
	logic        chatter_en  = 1'b0;
	logic [7:0]  reg_addr    = 8'h00;
	logic [31:0] reg_wdata   = 32'h00000000;
	logic [2:0]  contact_cmd = 3'h0;
	logic [31:0] reg_rdata, d;
	logic [2:0]  pins;
	logic [4:0]  drive, coil_on;
	logic        relay, fault_contact;
	dic_note_t   notes[$];
	int          miscompares, cmp_count, cyc, t, t1, t2, dly, dly2;
	int          seed = 57;

	dic_conditioner_top #(.MS_CYCLES(MS)) dic_conditioner_top_inst (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .input_channel_n(pins), .fault_pin(fault_pin),
		.output_channel_n(drive), .sys_fault_relay(relay));

	dic_field_model dic_field_model_inst (.clk(clk), .contact_cmd(contact_cmd), .chatter_en(chatter_en),
		.pin_level(pins), .relay_drive(drive), .fault_drive(relay), .coil_on(coil_on),
		.fault_contact(fault_contact));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic window(input string name, input int v, input int lo, input int hi);
		cmp_count++;
		if (v < lo || v > hi) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, v);
		end
	endtask : window

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		notes.push_back(dic_note_t'{c, e, m});
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// Polls status until one bit reaches a level; t holds the cycles taken
	task automatic wait_st(input int b, input logic want);
		t1 = cyc;
		d  = ~{32{want}};
		while (d[b] !== want && cyc - t1 < 3000)
			rd(`DIC_OFF_STATUS, 1'b0, 32'h00000000, 32'h00000000);
		t = cyc - t1;
	endtask : wait_st

	task automatic wait_coil(input logic [4:0] e, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (coil_on !== e && n < 3000);
	endtask : wait_coil

	task automatic chk_relay(input logic e);
		repeat (4) @(posedge clk);
		#1;
		check("fault relay", {31'h0, e}, {31'h0, relay});
		check("fault contact", {31'h0, ~e}, {31'h0, fault_contact});
	endtask : chk_relay

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// Read results are matched against the oldest note when they appear
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_q && notes.size() > 0) begin
			if (notes[0].chk)
				check("reg_rdata", notes[0].exp & notes[0].mask, reg_rdata & notes[0].mask);
			void'(notes.pop_front());
		end else if (reset_n)
			check("idle reg_rdata", 32'h00000000, reg_rdata);
		rd_q <= reg_rd;
		if (cyc == LIMIT) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		// Unmapped and read-only places must ignore writes
		wr(8'h3C, 32'hFFFFFFFF);
		wr(`DIC_OFF_STATUS, 32'hFFFFFFFF);
		foreach (REGS[i]) rd(REGS[i], 1'b1, 32'h00000000, 32'hFFFFFFFF);
		rd(`DIC_OFF_STATUS, 1'b1, 32'h00010000, 32'hFFFFFFFF);
		wr(`DIC_OFF_CTRL, 32'h00000007);
		wait_st(0, 1'b1);
		window("polarity pickup", t, 0, SCAN + 8);
		rd(`DIC_OFF_STATUS, 1'b1, 32'h00000007, 32'h00000007);
		wr(`DIC_OFF_CTRL, 32'h00000000);
		wait_st(0, 1'b0);
		window("polarity release", t, 0, SCAN + 8);
		dly  = 2 + {$random(seed)} % 4;
		dly2 = 2 + {$random(seed)} % 4;
		wr(`DIC_OFF_ACT_BASE + 8'h04, dly);
		wr(`DIC_OFF_DROP_BASE + 8'h04, dly2);
		contact_cmd[1] <= 1'b1;
		wait_st(1, 1'b1);
		window("activation delay", t, (dly - 1) * MS, (dly + 5) * MS + 8);
		contact_cmd[1] <= 1'b0;
		wait_st(1, 1'b0);
		window("drop-off delay", t, (dly2 - 1) * MS, (dly2 + 5) * MS + 8);
		wr(`DIC_OFF_CTRL, 32'h00000040);
		wr(`DIC_OFF_DROP_BASE + 8'h08, 32'h00000002);
		contact_cmd[2] <= 1'b1;
		wait_st(2, 1'b1);
		contact_cmd[2] <= 1'b0;
		wait_st(2, 1'b0);
		window("ac hold-off", t, (`DIC_AC_HOLD_MS + 1) * MS, (`DIC_AC_HOLD_MS + 7) * MS + 8);
		// Two pulses shorter than the delay must not add up to a pickup
		wr(`DIC_OFF_ACT_BASE, 32'h00000008);
		repeat (2) begin
			contact_cmd[0] <= 1'b1;
			repeat (30) @(posedge clk);
			contact_cmd[0] <= 1'b0;
			repeat (60) rd(`DIC_OFF_STATUS, 1'b1, 32'h00000000, 32'h00000001);
		end
		contact_cmd[0] <= 1'b1;
		wait_st(0, 1'b1);
		window("restarted pickup", t, 7 * MS, 13 * MS + 8);
		contact_cmd[0] <= 1'b0;
		wait_st(0, 1'b0);
		// Stage lags status by a scan; a stale stage would cut the latency short
		wait_st(4, 1'b0);
		wr(`DIC_OFF_ACT_BASE, 32'h00000000);
		wr(`DIC_OFF_ROUTE, 32'h00000309);
		contact_cmd[0] <= 1'b1;
		fork
			begin
				wait_st(4, 1'b1);
				window("stage latency", t, SCAN, 2 * SCAN + 8);
			end
			begin
				wait_coil(5'h01, t2);
				window("routed output latency", t2, 2 * SCAN, 3 * SCAN + 8);
			end
		join
		rd(`DIC_OFF_STATUS, 1'b1, 32'h00000111, 32'h00001F71);
		contact_cmd[0] <= 1'b0;
		wait_coil(5'h00, t2);
		window("routed output release", t2, 2 * SCAN, 3 * SCAN + 8);
		wr(`DIC_OFF_ROUTE, 32'h00000000);
		wr(`DIC_OFF_OUT_CTL, 32'h0000001F);
		wait_coil(5'h1F, t2);
		window("output refresh", t2, 1, SCAN + 2);
		wr(`DIC_OFF_OUT_CTL, 32'h0000000A);
		wait_coil(5'h0A, t2);
		window("output refresh period", t2 + 2, SCAN, SCAN);
		wr(`DIC_OFF_OUT_CTL, 32'h00000000);
		fault_pin <= 1'b1;
		chk_relay(1'b0);
		rd(`DIC_OFF_STATUS, 1'b1, 32'h00020000, 32'h00030000);
		fault_pin <= 1'b0;
		chk_relay(1'b1);
		wr(`DIC_OFF_FAULT, 32'h00000001);
		chk_relay(1'b0);
		wr(`DIC_OFF_FAULT, 32'h00000000);
		chk_relay(1'b1);
		// Bouncing contacts must still count one pickup per closure
		wr(`DIC_OFF_CNT_BASE, 32'h00000000);
		chatter_en <= 1'b1;
		repeat (3) begin
			contact_cmd[0] <= 1'b1;
			wait_st(0, 1'b1);
			contact_cmd[0] <= 1'b0;
			wait_st(0, 1'b0);
		end
		rd(`DIC_OFF_CNT_BASE, 1'b1, 32'h00000003, 32'hFFFFFFFF);
		rd(`DIC_OFF_CNT_BASE + 8'h04, 1'b1, 32'h00000002, 32'hFFFFFFFF);
		rd(`DIC_OFF_CNT_BASE + 8'h08, 1'b1, 32'h00000002, 32'hFFFFFFFF);
		report_and_stop();
	end
endmodule : dic_conditioner_tb_top
